// [hdl/voter_diag_pkg.sv]
// Package: constants and carriers for the triple-channel output voter block.
// Assumes a single 200 MHz system clock; all timing is counted in its cycles.
package voter_diag_pkg;

    localparam int CLK_MHZ           = 200;
    // Longest forced transition on DC outputs, in microseconds
    localparam int DC_GLITCH_MAX_US  = 2000;
    // Typical forced transition length on DC outputs, in microseconds
    localparam int DC_GLITCH_TYP_US  = 500;
    localparam int DC_GLITCH_CYCLES  = DC_GLITCH_TYP_US * CLK_MHZ;
    localparam int DC_GLITCH_LIMIT   = (DC_GLITCH_MAX_US * CLK_MHZ) - 1;
    // Pause between inversion steps, in cycles
    localparam int STEP_GAP_CYCLES   = 16;
    localparam int POINT_IDX_RESET   = 0;

    typedef enum logic [3:0] {
        SEQ_IDLE  = 4'b0001,
        SEQ_FORCE = 4'b0010,
        SEQ_GAP   = 4'b0100,
        SEQ_HALT  = 4'b1000
    } seq_state_e;

    // One channel's command word plus its strobe
    typedef struct packed {
        logic        load;
        logic [15:0] cmd;
    } chan_cmd_s;

endpackage

// [hdl/majority_vote.sv]
// Two-of-three majority vote on one switch path per point.
// Assumes the three channel driver vectors are already in the clock domain.
`timescale 1ns/1ps
module majority_vote
    import voter_diag_pkg::*;
#(
    parameter int POINTS = 16
) (
    // Driver commands of channels A, B and C
    input  wire logic [POINTS-1:0] drvA,
    input  wire logic [POINTS-1:0] drvB,
    input  wire logic [POINTS-1:0] drvC,
    // Voted switch state
    output logic      [POINTS-1:0] voted
);
    assign voted = (drvA & drvB) | (drvB & drvC) | (drvA & drvC);
endmodule

// [hdl/tmr_output_voter_diagnostics.sv]
// Triple-channel digital output voter with driver inversion diagnostic.
// Assumes each channel's command port is fed only by its own processor and
// that the loopback inputs are synchronous to sys_clk.
`timescale 1ns/1ps

// What this block does
// - Each channel loads only its own command
// - Load energised when two drivers agree
// - Dual variant drives the vote on the series switches, parallel held off
// - Invert one driver at one point at a time, stepping through all points
// - Loopback mismatch during inversion flags fault
// - AC inversion lasts at most half cycle
// - DC inversion under 2 ms, typically 500 us
// - AC variant halts diagnostic after fault
// - Diagnostic can be switched off
// - DC diagnostic covers points never changing
module tmr_output_voter_diagnostics
    import voter_diag_pkg::*;
#(
    parameter int POINTS       = 16,
    // Half mains cycle in sys_clk cycles (50 Hz default)
    parameter int AC_HALF_CYC  = 2000000,
    parameter int DC_GLITCH    = DC_GLITCH_CYCLES
) (
    // Clock, reset, enable
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire logic              clkEn,
    // Channel command ports
    input  wire chan_cmd_s         cmdA,
    input  wire chan_cmd_s         cmdB,
    input  wire chan_cmd_s         cmdC,
    // Configuration
    input  wire logic              diagEnable,
    input  wire logic              acVariant,
    input  wire logic              dualVariant,
    // Loopback of the switched points
    input  wire logic [POINTS-1:0] loopback,
    // Field side
    output logic      [POINTS-1:0] loadOut,
    output logic      [POINTS-1:0] switchSeries,
    output logic      [POINTS-1:0] switchParallel,
    // Status
    output logic      [2:0]        latentFault,
    output logic                   diagActive,
    output logic                   diagHalted
);
    localparam int PW = $clog2(POINTS);

    // Command word carries 16 points, so no more can be served
    if (POINTS < 2 || POINTS > ($bits(chan_cmd_s) - 1)) begin : g_badPoints
        $error("POINTS out of range");
    end
    if (DC_GLITCH < 1 || DC_GLITCH > DC_GLITCH_LIMIT) begin : g_badDc
        $error("DC_GLITCH above 2 ms");
    end
    if (AC_HALF_CYC < 1) begin : g_badAc
        $error("AC_HALF_CYC below one cycle");
    end

    typedef struct packed {
        seq_state_e        state;
        logic [POINTS-1:0] tableA;
        logic [POINTS-1:0] tableB;
        logic [POINTS-1:0] tableC;
        logic [PW-1:0]     point;
        logic [1:0]        chan;
        logic [31:0]       timer;
        logic [2:0]        fault;
        logic [POINTS-1:0] loadOut;
        logic [POINTS-1:0] swSer;
        logic [POINTS-1:0] swPar;
        logic              active;
    } state_s;

    state_s cur;
    state_s next_cur;

    logic [POINTS-1:0] drvA;
    logic [POINTS-1:0] drvB;
    logic [POINTS-1:0] drvC;
    logic [POINTS-1:0] voted;
    logic [POINTS-1:0] pointMask;
    logic [31:0]       glitchLen;

    function automatic logic [POINTS-1:0] one_hot(input logic [PW-1:0] idx);
        one_hot = '0;
        one_hot[idx] = 1'b1;
    endfunction

    // Half mains cycle bound on AC
    // Typical 500 us pulse on DC
    assign glitchLen = acVariant ? 32'(AC_HALF_CYC) : 32'(DC_GLITCH);
    assign pointMask = one_hot(cur.point);

    always_comb begin
        drvA = cur.tableA;
        drvB = cur.tableB;
        drvC = cur.tableC;
        if (cur.state == SEQ_FORCE) begin
            if (cur.chan == 2'h0) begin
                drvA = cur.tableA ^ pointMask;
            end else if (cur.chan == 2'h1) begin
                drvB = cur.tableB ^ pointMask;
            end else begin
                drvC = cur.tableC ^ pointMask;
            end
        end
    end

    majority_vote #(.POINTS(POINTS)) u_vote (
        .drvA  (drvA),
        .drvB  (drvB),
        .drvC  (drvC),
        .voted (voted)
    );

    always_comb begin
        next_cur = cur;
        if (cmdA.load) next_cur.tableA = cmdA.cmd[POINTS-1:0];
        if (cmdB.load) next_cur.tableB = cmdB.cmd[POINTS-1:0];
        if (cmdC.load) next_cur.tableC = cmdC.cmd[POINTS-1:0];
        next_cur.loadOut = voted;
        next_cur.swSer   = dualVariant ? voted : '0;
        next_cur.swPar   = dualVariant ? '0 : voted;
        next_cur.active  = 1'b0;
        case (cur.state)
            SEQ_IDLE: begin
                if (diagEnable) begin
                    next_cur.state = SEQ_FORCE;
                    next_cur.timer = '0;
                end
                // After an AC fault, abort then re-enable must not restart
                if (acVariant && (cur.fault != 3'h0)) begin
                    next_cur.state = SEQ_HALT;
                end
            end
            SEQ_FORCE: begin
                next_cur.active = 1'b1;
                next_cur.timer  = cur.timer + 32'h1;
                // Loopback must show the voted value
                if (cur.timer == (glitchLen - 32'h1)) begin
                    if (loopback[cur.point] != cur.loadOut[cur.point]) begin
                        next_cur.fault[cur.chan] = 1'b1;
                    end
                    next_cur.timer = '0;
                    next_cur.state = SEQ_GAP;
                end
                if (!diagEnable) begin
                    next_cur.state = SEQ_IDLE;
                    next_cur.timer = '0;
                end
            end
            SEQ_GAP: begin
                next_cur.timer = cur.timer + 32'h1;
                if (cur.timer == 32'(STEP_GAP_CYCLES - 1)) begin
                    next_cur.timer = '0;
                    if (cur.chan == 2'h2) begin
                        next_cur.chan  = 2'h0;
                        next_cur.point = (cur.point == PW'(POINTS - 1)) ? '0 : cur.point + PW'(1);
                    end else begin
                        next_cur.chan = cur.chan + 2'h1;
                    end
                    if (acVariant && (cur.fault != 3'h0)) begin
                        next_cur.state = SEQ_HALT;
                    end else begin
                        next_cur.state = diagEnable ? SEQ_FORCE : SEQ_IDLE;
                    end
                end
            end
            SEQ_HALT: begin
                next_cur.state = SEQ_HALT;
            end
            default: begin
                next_cur.state = SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cur <= '{state: SEQ_IDLE, point: PW'(POINT_IDX_RESET), default: '0};
        end else if (clkEn) begin
            cur <= next_cur;
        end
    end

    assign loadOut        = cur.loadOut;
    assign switchSeries   = cur.swSer;
    assign switchParallel = cur.swPar;
    assign latentFault    = cur.fault;
    assign diagActive     = cur.active;
    // One-hot halt bit, straight from its flop
    assign diagHalted     = cur.state[3];

    forceLenDc_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (!acVariant && cur.state == SEQ_FORCE) |-> cur.timer < 32'(DC_GLITCH_LIMIT))
        else $error("DC inversion too long");
    forceLenAc_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (acVariant && cur.state == SEQ_FORCE) |-> cur.timer < 32'(AC_HALF_CYC))
        else $error("AC inversion too long");
    haltStays_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (cur.state == SEQ_HALT) |=> (cur.state == SEQ_HALT))
        else $error("Halted sequencer restarted");
    acHalt_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (clkEn && acVariant && cur.state == SEQ_GAP && next_cur.state == SEQ_FORCE) |-> cur.fault == 3'h0)
        else $error("AC diagnostic ran after fault");
    offNoForce_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (!diagEnable && cur.state == SEQ_IDLE) |=> cur.state != SEQ_FORCE)
        else $error("Inversion while disabled");
    plainDrive_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (cur.state != SEQ_FORCE) |-> (drvA == cur.tableA && drvB == cur.tableB && drvC == cur.tableC))
        else $error("Driver inverted outside step");
    oneDriver_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (cur.state == SEQ_FORCE) |-> $countones({drvA ^ cur.tableA, drvB ^ cur.tableB, drvC ^ cur.tableC}) == 1)
        else $error("Not exactly one driver inverted");
    voteOut_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        clkEn |=> loadOut == (($past(drvA) & $past(drvB)) | ($past(drvB) & $past(drvC)) | ($past(drvA) & $past(drvC))))
        else $error("Load not majority of drivers");
    ownLoad_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (clkEn && cmdB.load) |=> cur.tableB == $past(cmdB.cmd[POINTS-1:0]))
        else $error("Channel B table not loaded");
    faultFlag_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (clkEn && cur.state == SEQ_FORCE && cur.timer == glitchLen - 32'h1
         && loopback[cur.point] != cur.loadOut[cur.point]) |=> latentFault[$past(cur.chan)])
        else $error("Loopback mismatch not flagged");

    stepDone_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
        cur.state == SEQ_FORCE ##1 cur.state == SEQ_GAP);
    faultSeen_c: cover property (@(posedge sys_clk) disable iff (sys_rst) latentFault != 3'h0);
    halted_c: cover property (@(posedge sys_clk) disable iff (sys_rst) diagHalted);
endmodule

// [bench/proc_field_model.sv]
// Model of the three processor channels and the field loopback path.
// Assumes the bench changes tables, strobe and fault mask at the falling edge.
`timescale 1ns/1ps
module proc_field_model
    import voter_diag_pkg::*;
(
    // Bench side
    input  wire logic [15:0] tblA,
    input  wire logic [15:0] tblB,
    input  wire logic [15:0] tblC,
    input  wire logic        send,
    input  wire logic [15:0] faultMask,
    // Block side
    input  wire logic [15:0] loadOut,
    output chan_cmd_s        cmdA,
    output chan_cmd_s        cmdB,
    output chan_cmd_s        cmdC,
    output logic      [15:0] loopback
);
    assign cmdA = '{load: send, cmd: tblA};
    assign cmdB = '{load: send, cmd: tblB};
    assign cmdC = '{load: send, cmd: tblC};
    // Masked points read back inverted from loadOut
    assign loopback = loadOut ^ faultMask;
endmodule

// [bench/tb_top.sv]
// Self-checking bench for the triple-channel output voter.
// Assumes short simulation timings set through the block parameters.
`timescale 1ns/1ps
module tb_top;
    import voter_diag_pkg::*;
    logic sysClk = 0, sysRst = 1, send = 0, diagEnable = 0, acVariant = 0, dualVariant = 0, clkEn = 1;
    logic [15:0] tblA = 0, tblB = 0, tblC = 0, faultMask = 0, a, b, c;
    logic [15:0] loopback, loadOut, switchSeries, switchParallel;
    logic [2:0]  latentFault;
    logic        diagActive, diagHalted;
    chan_cmd_s   cmdA, cmdB, cmdC;
    int seed = 56, mismatches = 0, check_count = 0, run = 0, maxRun = 0;

    always #2.5 sysClk = ~sysClk;

    proc_field_model PM (.tblA(tblA), .tblB(tblB), .tblC(tblC), .send(send), .faultMask(faultMask),
        .loadOut(loadOut), .cmdA(cmdA), .cmdB(cmdB), .cmdC(cmdC), .loopback(loopback));

    tmr_output_voter_diagnostics #(.POINTS(16), .AC_HALF_CYC(20), .DC_GLITCH(10)) DUT (
        .sys_clk(sysClk), .sys_rst(sysRst), .clkEn(clkEn), .cmdA(cmdA), .cmdB(cmdB), .cmdC(cmdC),
        .diagEnable(diagEnable), .acVariant(acVariant), .dualVariant(dualVariant),
        .loopback(loopback), .loadOut(loadOut), .switchSeries(switchSeries),
        .switchParallel(switchParallel), .latentFault(latentFault), .diagActive(diagActive),
        .diagHalted(diagHalted));

    // Longest unbroken inversion seen, sampled off the launching edge
    always @(negedge sysClk) begin
        if (diagActive === 1'b1) begin
            run++;
            if (run > maxRun) maxRun = run;
        end else begin
            run = 0;
        end
    end

    function automatic logic [15:0] maj(input logic [15:0] x, y, z);
        return (x & y) | (y & z) | (x & z);
    endfunction

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic load3(input logic [15:0] x, y, z);
        @(negedge sysClk);
        tblA = x;
        tblB = y;
        tblC = z;
        send = 1;
        @(negedge sysClk);
        send = 0;
        repeat (2) @(negedge sysClk);
    endtask

    task automatic do_reset();
        sysRst = 1;
        repeat (6) @(negedge sysClk);
        sysRst = 0;
        maxRun = 0;
    endtask

    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        #200000;
        mismatches++;
        stop_test();
    end

    initial begin
        do_reset();
        check({13'h0, latentFault}, 16'h0);
        for (int i = 0; i < 24; i++) begin
            a = 16'($random(seed));
            b = (i < 4) ? ~a : 16'($random(seed));
            c = 16'($random(seed));
            faultMask = 16'($random(seed));
            dualVariant = i[0];
            load3(a, b, c);
            check(loadOut, maj(a, b, c));
            check(dualVariant ? switchSeries : switchParallel, maj(a, b, c));
            check(dualVariant ? switchParallel : switchSeries, 16'h0);
            check({13'h0, latentFault}, 16'h0);
        end
        // Frozen block must ignore a load strobe
        clkEn = 0;
        load3(~a, ~b, ~c);
        check(loadOut, maj(a, b, c));
        clkEn = 1;
        $display("test vote done");
        faultMask = 0;
        load3(16'hffff, 16'hffff, 16'hffff);
        check(loadOut, 16'hffff);
        load3(16'h0, 16'h0, 16'h0);
        check(loadOut, 16'h0);
        load3(16'h5a5a, 16'h5a5a, 16'h5a5a);
        diagEnable = 1;
        repeat (1500) @(negedge sysClk);
        check(loadOut, 16'h5a5a);
        check(maxRun[15:0], 16'd10);
        check({13'h0, latentFault}, 16'h0);
        faultMask = 16'h8000;
        repeat (1500) @(negedge sysClk);
        check({13'h0, latentFault}, 16'h7);
        check({15'h0, diagHalted}, 16'h0);
        diagEnable = 0;
        repeat (40) @(negedge sysClk);
        check({15'h0, diagActive}, 16'h0);
        $display("test dc done");
        acVariant = 1;
        faultMask = 16'h0001;
        do_reset();
        load3(16'hffff, 16'hffff, 16'hffff);
        diagEnable = 1;
        repeat (300) @(negedge sysClk);
        check({15'h0, diagHalted}, 16'h1);
        check({13'h0, latentFault}, 16'h1);
        check(maxRun[15:0], 16'd20);
        $display("test ac done");
        stop_test();
    end
endmodule
